/* File: etx_encoder.sv */
// Zero-substitution line encoder, advanced once per transmit clock bit.
// Assumes i_bit_strobe is a one-cycle pulse on the system clock for each new bit.
`timescale 1ns/100ps
`default_nettype none
module etx_encoder (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // Bit stream
  input wire logic i_bit_strobe,
  input wire logic i_data,
  input wire logic i_hdb3,
  // Encoded rails
  output logic o_pos,
  output logic o_neg
);
  // Delay line holds the bits that a substitution may still rewrite.
  logic [3:0] pipe_reg;
  logic [3:0] mark_reg;
  logic [3:0] viol_reg;
  logic last_pol_reg;
  logic odd_reg;
  logic zero_run;
  logic [3:0] ins_mark;
  logic [3:0] ins_viol;
  logic out_mark;
  logic out_viol;
  logic pol_next;

  always_comb begin
    // Incoming bit joins slot 0; a full run of zeros triggers the rewrite.
    ins_mark = {mark_reg[2:0], i_data};
    ins_viol = {viol_reg[2:0], 1'b0};
    zero_run = i_hdb3 ? (ins_mark == 4'h0) : (ins_mark[2:0] == 3'h0);
    // A run of zeros never holds a violation, so back-to-back runs are each replaced.
    if (zero_run) begin
      if (i_hdb3) begin
        // Even marks since the last violation: B00V, else 000V.
        ins_mark = {!odd_reg, 3'h1};
        ins_viol = 4'h1;
      end else begin
        // Even marks: B0V, else 00V.
        ins_mark = {ins_mark[3], !odd_reg, 2'h1};
        ins_viol = 4'h1;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      mark_reg <= 4'h0;
      viol_reg <= 4'h0;
      pipe_reg <= 4'h0;
    end else if (i_bit_strobe) begin
      mark_reg <= ins_mark;
      viol_reg <= ins_viol;
      pipe_reg <= {pipe_reg[2:0], 1'b1};
    end
  end

  // Output taps slot 3 for HDB3 and slot 2 otherwise; a violation repeats the previous polarity.
  assign out_mark = i_hdb3 ? mark_reg[3] : mark_reg[2];
  assign out_viol = i_hdb3 ? viol_reg[3] : viol_reg[2];
  assign pol_next = out_viol ? last_pol_reg : !last_pol_reg;

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      last_pol_reg <= 1'b0;
      odd_reg <= 1'b0;
      o_pos <= 1'b0;
      o_neg <= 1'b0;
    end else if (i_bit_strobe) begin
      o_pos <= out_mark && pol_next && (i_hdb3 ? pipe_reg[3] : pipe_reg[2]);
      o_neg <= out_mark && !pol_next && (i_hdb3 ? pipe_reg[3] : pipe_reg[2]);
      if (out_mark) begin
        last_pol_reg <= pol_next;
      end
      // Parity counts marks entering the line since the newest violation.
      if (zero_run) begin
        odd_reg <= 1'b0;
      end else if (i_data) begin
        odd_reg <= !odd_reg;
      end
    end
  end
endmodule
`default_nettype wire

/* File: etx_framer_model.sv */
// Framer model: streams two 32-bit rail patterns under a gated 800 ns rate clock.
// Assumes the bench starts and stops a frame with i_run; patterns repeat every 32 bits.
`timescale 1ns/100ps
`default_nettype none
module etx_framer_model (
  // Control from the bench
  input wire logic i_run,
  input wire logic i_single,
  input wire logic [31:0] i_pos_bits,
  input wire logic [31:0] i_neg_bits,
  // Framer outputs
  output logic o_rate_clock,
  output logic o_pos,
  output logic o_neg,
  output var int o_count
);
  initial begin
    o_rate_clock = 1'b0;
    o_pos = 1'b0;
    o_neg = 1'b0;
    o_count = 0;
  end
  // Data moves at the falling edge, half a period clear of the sampling edge.
  always begin
    if (i_run) begin
      o_pos = i_pos_bits[o_count[4:0]];
      o_neg = i_single ? 1'b0 : i_neg_bits[o_count[4:0]];
      o_count = o_count + 1;
      #400 o_rate_clock = 1'b1;
      #400 o_rate_clock = 1'b0;
    end else begin
      // Between frames the clock stands still and the rails show no stale data.
      #37 o_pos = ~o_pos;
      o_neg = i_single ? 1'b0 : ~o_neg;
      o_count = 0;
    end
  end
endmodule
`default_nettype wire

/* File: etx_line_encoder.sv */
// Transmit path top: rail format select, zero substitution, build-out, drive monitor, enable.
// Assumes the transmit rate clock and rail inputs are asynchronous and sampled by i_clock.
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module etx_line_encoder #(
  parameter int FAULT_COUNT = etx_pkg::FAULT_PERIODS
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [31:0] o_rdata,
  // Configuration pins
  input wire logic i_rail_format_select,
  input wire logic i_build_out_select,
  input wire logic i_transmitter_on,
  input wire logic [1:0] i_line_rate,
  // Framer side
  input wire logic i_transmit_rate_clock,
  input wire logic i_tx_positive_rail_in,
  input wire logic i_tx_negative_rail_in,
  // Monitor inputs
  input wire logic i_monitor_positive_in,
  input wire logic i_monitor_negative_in,
  // Line side
  output logic o_line_out_positive,
  output logic o_line_out_negative,
  output logic o_line_out_positive_oe,
  output logic o_line_out_negative_oe,
  output logic o_build_out_en,
  output logic o_drive_fault_out,
  output logic o_irq
);
  localparam int CW = $clog2(FAULT_COUNT + 1);

  logic [6:0] ctrl_reg;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_mask_reg;
  logic [2:0] clk_sync_reg;
  logic [1:0] pos_sync_reg;
  logic [1:0] neg_sync_reg;
  logic [1:0] mpos_sync_reg;
  logic [1:0] mneg_sync_reg;
  logic [1:0] pin_sync_reg;
  logic [1:0] rsel_sync_reg;
  logic [1:0] bsel_sync_reg;
  logic [3:0] rate_sync_reg;
  logic bit_strobe;
  logic host_mode;
  logic single_rail;
  logic hdb3;
  logic [1:0] rate;
  logic enc_pos;
  logic enc_neg;
  logic line_pos_reg;
  logic line_neg_reg;
  logic tx_enabled;
  logic mon_pos_prev_reg;
  logic mon_neg_prev_reg;
  logic mon_pos;
  logic mon_neg;
  logic transition;
  logic [CW-1:0] idle_count_reg;
  logic fault_reg;
  logic fault_prev_reg;
  logic [1:0] irq_events;
  logic [2:0] status;

  // Two-flop synchronisers; the third clock stage is only for edge detection.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      clk_sync_reg <= 3'h0;
      pos_sync_reg <= 2'h0;
      neg_sync_reg <= 2'h0;
      mpos_sync_reg <= 2'h0;
      mneg_sync_reg <= 2'h0;
      pin_sync_reg <= 2'h0;
      rsel_sync_reg <= 2'h0;
      bsel_sync_reg <= 2'h0;
      rate_sync_reg <= 4'h0;
    end else begin
      rsel_sync_reg <= {rsel_sync_reg[0], i_rail_format_select};
      bsel_sync_reg <= {bsel_sync_reg[0], i_build_out_select};
      rate_sync_reg <= {rate_sync_reg[1:0], i_line_rate};
      clk_sync_reg <= {clk_sync_reg[1:0], i_transmit_rate_clock};
      pos_sync_reg <= {pos_sync_reg[0], i_tx_positive_rail_in};
      neg_sync_reg <= {neg_sync_reg[0], i_tx_negative_rail_in};
      mpos_sync_reg <= {mpos_sync_reg[0], i_monitor_positive_in};
      mneg_sync_reg <= {mneg_sync_reg[0], i_monitor_negative_in};
      pin_sync_reg <= {pin_sync_reg[0], i_transmitter_on};
    end
  end

  // Data is taken on the rising edge of the sampled rate clock, so any duty cycle works.
  assign bit_strobe = clk_sync_reg[1] && !clk_sync_reg[2];

  // Configuration: host mode takes the control bits, hardware mode the pins.
  assign host_mode = ctrl_reg[etx_pkg::CTRL_HOST_MODE];
  assign single_rail = host_mode ? ctrl_reg[etx_pkg::CTRL_RAIL_FORMAT]
                                 : rsel_sync_reg[1];
  assign rate = host_mode ? ctrl_reg[etx_pkg::CTRL_RATE_LO +: 2] : rate_sync_reg[3:2];
  assign hdb3 = (rate == etx_pkg::RATE_E3);

  etx_encoder u_encoder (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_bit_strobe(bit_strobe),
    .i_data(pos_sync_reg[1]),
    .i_hdb3(hdb3),
    .o_pos(enc_pos),
    .o_neg(enc_neg)
  );

  // Dual-rail data goes straight through; violations are sent as ordinary pulses.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      line_pos_reg <= 1'b0;
      line_neg_reg <= 1'b0;
    end else if (bit_strobe) begin
      if (single_rail) begin
        line_pos_reg <= enc_pos;
        line_neg_reg <= enc_neg;
      end else begin
        line_pos_reg <= pos_sync_reg[1];
        line_neg_reg <= neg_sync_reg[1];
      end
    end
  end

  // Host mode still needs the pin high, so a pulled pin always shuts the card off.
  assign tx_enabled = pin_sync_reg[1] && (!host_mode || ctrl_reg[etx_pkg::CTRL_TX_ON]);
  assign o_line_out_positive = line_pos_reg;
  assign o_line_out_negative = line_neg_reg;
  assign o_line_out_positive_oe = tx_enabled;
  assign o_line_out_negative_oe = tx_enabled;

  // Build-out is active low on its select and never used at the E3 rate.
  assign o_build_out_en = !hdb3 && !(host_mode ? ctrl_reg[etx_pkg::CTRL_BUILD_OUT]
                                               : bsel_sync_reg[1]);

  // Drive monitor source: own driver outputs or the external monitor pins.
  assign mon_pos = ctrl_reg[etx_pkg::CTRL_DRIVE_MON] ? (line_pos_reg && tx_enabled)
                                                    : mpos_sync_reg[1];
  assign mon_neg = ctrl_reg[etx_pkg::CTRL_DRIVE_MON] ? (line_neg_reg && tx_enabled)
                                                    : mneg_sync_reg[1];
  assign transition = (mon_pos != mon_pos_prev_reg) || (mon_neg != mon_neg_prev_reg);

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      mon_pos_prev_reg <= 1'b0;
      mon_neg_prev_reg <= 1'b0;
      idle_count_reg <= '0;
      fault_reg <= 1'b0;
    end else begin
      mon_pos_prev_reg <= mon_pos;
      mon_neg_prev_reg <= mon_neg;
      if (transition) begin
        idle_count_reg <= '0;
        fault_reg <= 1'b0;
      end else if (bit_strobe) begin
        if (idle_count_reg == CW'(FAULT_COUNT)) begin
          fault_reg <= 1'b1;
        end else begin
          idle_count_reg <= idle_count_reg + CW'(1);
        end
      end
    end
  end
  assign o_drive_fault_out = fault_reg;

  // Sticky interrupts for fault raise and clear; a new event beats a write-one clear.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      fault_prev_reg <= 1'b0;
    end else begin
      fault_prev_reg <= fault_reg;
    end
  end
  assign irq_events = {!fault_reg && fault_prev_reg, fault_reg && !fault_prev_reg};

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_stat_reg <= 2'h0;
    end else begin
      if (i_write && (i_addr == etx_pkg::IRQ_STAT_ADDR)) begin
        irq_stat_reg <= (irq_stat_reg & ~i_wdata[1:0]) | irq_events;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_events;
      end
    end
  end
  assign o_irq = |(irq_stat_reg & irq_mask_reg);

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_reg <= etx_pkg::CTRL_RESET;
      irq_mask_reg <= 2'h0;
    end else if (i_write) begin
      if (i_addr == etx_pkg::CTRL_ADDR) begin
        ctrl_reg <= i_wdata[etx_pkg::CTRL_WIDTH-1:0];
      end
      if (i_addr == etx_pkg::IRQ_MASK_ADDR) begin
        irq_mask_reg <= i_wdata[etx_pkg::IRQ_WIDTH-1:0];
      end
    end
  end

  assign status = {o_build_out_en, tx_enabled, fault_reg};

  // Read data valid the cycle after the strobe; unmapped addresses read zero.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 32'h0;
    end else if (i_read) begin
      unique case (i_addr)
        etx_pkg::CTRL_ADDR: o_rdata <= {25'h0, ctrl_reg};
        etx_pkg::STATUS_ADDR: o_rdata <= {29'h0, status};
        etx_pkg::IRQ_STAT_ADDR: o_rdata <= {30'h0, irq_stat_reg};
        etx_pkg::IRQ_MASK_ADDR: o_rdata <= {30'h0, irq_mask_reg};
        default: o_rdata <= 32'h0;
      endcase
    end else begin
      o_rdata <= 32'h0;
    end
  end

  fault_set_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (idle_count_reg == CW'(FAULT_COUNT)) && bit_strobe && !transition |=> fault_reg)
    else $error("fault not raised after idle threshold");
  fault_clear_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    transition |=> !fault_reg && (idle_count_reg == '0))
    else $error("fault not cleared by transition");
  idle_sat_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    idle_count_reg <= CW'(FAULT_COUNT))
    else $error("idle counter passed threshold");
  oe_off_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    !pin_sync_reg[1] |-> !o_line_out_positive_oe && !o_line_out_negative_oe)
    else $error("outputs driven with transmitter pin low");
  host_on_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    host_mode && !ctrl_reg[etx_pkg::CTRL_TX_ON] |-> !o_line_out_positive_oe)
    else $error("host mode drives without enable bit");
  e3_build_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    hdb3 |-> !o_build_out_en)
    else $error("build-out enabled at E3");
  dual_pass_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    bit_strobe && !single_rail |=> line_pos_reg == $past(pos_sync_reg[1]))
    else $error("dual-rail data not passed through");
  rails_excl_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    single_rail && $stable(single_rail) |-> !(enc_pos && enc_neg))
    else $error("encoder drove both rails");
endmodule
`default_nettype wire

/* File: etx_line_encoder_tb.sv */
// Testbench for the transmit line encoder: register tasks, rail streams and drive monitor.
// Assumes the framer model drives the link side and the bench owns the register port.
`timescale 1ns/100ps
`default_nettype none
module etx_line_encoder_tb;
  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_write = 1'b0;
  logic i_read = 1'b0;
  logic rail_sel = 1'b0;
  logic bo_sel = 1'b0;
  logic tx_pin = 1'b1;
  logic [1:0] rate = etx_pkg::RATE_DS3;
  logic mon_p = 1'b0;
  logic mon_live = 1'b0;
  logic run = 1'b0;
  logic single = 1'b0;
  logic [31:0] pbits = 32'h0;
  logic [31:0] nbits = 32'h0;
  logic [2:0] tick = 3'h0;
  logic [31:0] rdata;
  logic rclk, fpos, fneg, lpos, lneg, oep, oen, bo_en, fault, irq;
  int cnt;
  int cap_n = 0;
  int bad_count = 0;
  int checks_done = 0;
  logic [1:0] cap [40];
  logic [1:0] ex [32];
  localparam logic [31:0] DP = 32'h0005_9a4d;
  localparam logic [31:0] DN = 32'h000a_2410;
  localparam logic [31:0] SD = 32'h00fa_1031;

  etx_line_encoder #(.FAULT_COUNT(8)) u_etx_line_encoder (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_write(i_write), .i_read(i_read), .o_rdata(rdata),
    .i_rail_format_select(rail_sel), .i_build_out_select(bo_sel),
    .i_transmitter_on(tx_pin), .i_line_rate(rate), .i_transmit_rate_clock(rclk),
    .i_tx_positive_rail_in(fpos), .i_tx_negative_rail_in(fneg),
    .i_monitor_positive_in(mon_p), .i_monitor_negative_in(1'b0),
    .o_line_out_positive(lpos), .o_line_out_negative(lneg),
    .o_line_out_positive_oe(oep), .o_line_out_negative_oe(oen),
    .o_build_out_en(bo_en), .o_drive_fault_out(fault), .o_irq(irq));
  etx_framer_model u_etx_framer_model (
    .i_run(run), .i_single(single), .i_pos_bits(pbits), .i_neg_bits(nbits),
    .o_rate_clock(rclk), .o_pos(fpos), .o_neg(fneg), .o_count(cnt));

  initial begin
    forever #50 i_clock = ~i_clock;
  end
  // A live monitored line toggles every eight system cycles.
  always @(posedge i_clock) begin
    tick <= tick + 3'h1;
    if (mon_live && tick == 3'h0) mon_p <= ~mon_p;
  end
  // Each rate clock rise shows the symbol launched by the previous rise.
  always @(posedge rclk) begin
    if (cap_n < 40) cap[cap_n] = {lpos, lneg};
    cap_n++;
  end

  task close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_write <= 1'b1;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clock);
    i_addr <= a;
    i_read <= 1'b1;
    @(posedge i_clock);
    i_read <= 1'b0;
    @(negedge i_clock);
    chk("rdata", exp, rdata);
  endtask
  task do_reset;
    @(posedge i_clock);
    i_resetn <= 1'b0;
    repeat (8) @(posedge i_clock);
    i_resetn <= 1'b1;
  endtask
  task settle(input int n);
    repeat (n) @(posedge i_clock);
    @(negedge i_clock);
  endtask
  task wait_bits(input int n);
    int target;
    int guard;
    target = cnt + n;
    for (guard = 0; cnt < target; guard++) begin
      if (guard > n * 12 + 20) begin
        bad_count++;
        $display("BAD wait expected bits seen none");
        close_out();
      end
      @(posedge i_clock);
    end
  endtask
  // Reference zero substitution: first mark positive, mark count starts even, so a first substitution after an even number of marks uses a B pulse.
  task calc(input logic [31:0] d, input int n);
    logic [1:0] last;
    int pulses, z, i;
    last = 2'b01;
    pulses = 0;
    z = 0;
    for (i = 0; i < 32; i++) begin
      ex[i] = 2'b00;
      z++;
      if (d[i]) begin
        last = ~last;
        ex[i] = last;
        pulses++;
        z = 0;
      end else if (z == n) begin
        if (pulses % 2 == 0) begin
          last = ~last;
          ex[i - n + 1] = last;
        end
        ex[i] = last;
        pulses = 0;
        z = 0;
      end
    end
  endtask
  task run_stream(input logic [31:0] p, input logic [31:0] q, input int dly);
    int j;
    pbits <= p;
    nbits <= q;
    single <= (dly != 0);
    if (dly != 0) calc(p, dly);
    else for (j = 0; j < 32; j++) ex[j] = {p[j], q[j]};
    cap_n = 0;
    @(posedge i_clock);
    run <= 1'b1;
    wait_bits(24 + dly + 2);
    run <= 1'b0;
    // The line register adds one bit behind the encoder's own delay.
    for (j = 0; j < 24; j++) begin
      if (dly == 0) chk("line", {30'h0, ex[j]}, {30'h0, cap[j + 1]});
      else chk("line", (j <= dly) ? 32'h0 : {30'h0, ex[j - dly - 1]}, {30'h0, cap[j + 1]});
    end
  endtask

  initial begin
    do_reset();
    rd(etx_pkg::CTRL_ADDR, 32'h0);
    rd(8'h44, 32'h0);
    for (int k = 0; k < 3; k++) begin
      @(posedge i_clock);
      rate <= (k == 2) ? etx_pkg::RATE_E3 : etx_pkg::RATE_DS3;
      bo_sel <= (k == 1);
      settle(3);
      chk("build_out", (k == 0), {31'h0, bo_en});
    end
    rate <= etx_pkg::RATE_DS3;
    settle(4);
    chk("oe", 32'h3, {30'h0, oep, oen});
    tx_pin <= 1'b0;
    settle(4);
    chk("oe", 32'h0, {30'h0, oep, oen});
    tx_pin <= 1'b1;
    wr(etx_pkg::CTRL_ADDR, 32'h10);
    settle(4);
    chk("oe", 32'h0, {30'h0, oep, oen});
    wr(etx_pkg::CTRL_ADDR, 32'h18);
    settle(4);
    chk("oe", 32'h3, {30'h0, oep, oen});
    do_reset();
    run_stream(DP, DN, 0);
    do_reset();
    wr(etx_pkg::CTRL_ADDR, 32'h39);
    run_stream(SD, 32'h0, 3);
    do_reset();
    rail_sel <= 1'b1;
    rate <= etx_pkg::RATE_E3;
    run_stream(SD, 32'h0, 4);
    do_reset();
    rail_sel <= 1'b0;
    rate <= etx_pkg::RATE_DS3;
    pbits <= DP;
    nbits <= DN;
    single <= 1'b0;
    mon_live <= 1'b1;
    run <= 1'b1;
    wr(etx_pkg::IRQ_MASK_ADDR, 32'h3);
    wait_bits(20);
    chk("fault", 32'h0, {31'h0, fault});
    mon_live <= 1'b0;
    wait_bits(4);
    chk("fault", 32'h0, {31'h0, fault});
    wait_bits(8);
    chk("fault", 32'h1, {31'h0, fault});
    rd(etx_pkg::STATUS_ADDR, 32'h7);
    rd(etx_pkg::IRQ_STAT_ADDR, 32'h1);
    chk("irq", 32'h1, {31'h0, irq});
    wr(etx_pkg::IRQ_MASK_ADDR, 32'h0);
    settle(1);
    chk("irq", 32'h0, {31'h0, irq});
    wr(etx_pkg::IRQ_MASK_ADDR, 32'h3);
    wr(etx_pkg::IRQ_STAT_ADDR, 32'h1);
    settle(1);
    chk("irq", 32'h0, {31'h0, irq});
    mon_live <= 1'b1;
    wait_bits(3);
    chk("fault", 32'h0, {31'h0, fault});
    rd(etx_pkg::IRQ_STAT_ADDR, 32'h2);
    chk("irq", 32'h1, {31'h0, irq});
    mon_live <= 1'b0;
    pbits <= SD;
    single <= 1'b1;
    wr(etx_pkg::CTRL_ADDR, 32'h3d);
    wait_bits(20);
    chk("fault", 32'h0, {31'h0, fault});
    wr(etx_pkg::CTRL_ADDR, 32'h39);
    wait_bits(14);
    chk("fault", 32'h1, {31'h0, fault});
    close_out();
  end
endmodule
`default_nettype wire

/* File: etx_pkg.sv */
// Package for the transmit line encoder: register map, field positions and timing counts.
// Assumes a single 10 MHz system clock; the link clock is sampled as an ordinary input.
package etx_pkg;
  // Register byte addresses.
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'h08;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h0c;
  // Control register fields.
  localparam int CTRL_RAIL_FORMAT = 0;
  localparam int CTRL_BUILD_OUT = 1;
  localparam int CTRL_DRIVE_MON = 2;
  localparam int CTRL_TX_ON = 3;
  localparam int CTRL_HOST_MODE = 4;
  localparam int CTRL_RATE_LO = 5;
  localparam int CTRL_WIDTH = 7;
  localparam logic [6:0] CTRL_RESET = 7'h00;
  // Status and interrupt fields.
  localparam int STAT_FAULT = 0;
  localparam int STAT_TX_ENABLED = 1;
  localparam int STAT_BUILD_OUT = 2;
  localparam int IRQ_FAULT_SET = 0;
  localparam int IRQ_FAULT_CLR = 1;
  localparam int IRQ_WIDTH = 2;
  // Line rate codes.
  localparam logic [1:0] RATE_E3 = 2'h0;
  localparam logic [1:0] RATE_DS3 = 2'h1;
  localparam logic [1:0] RATE_STS1 = 2'h2;
  // Drive monitor threshold in transmit clock periods.
  localparam int FAULT_PERIODS = 128;
  localparam int FAULT_TOLERANCE = 32;
endpackage
